// file: rtl/dcl_consts.vh
/*
  constants for the dram column strobe lane decoder: size codes,
  port width codes, timing field layout and reset values.
  assumes inclusion by bare name from the rtl directory.
*/
`ifndef DCL_CONSTS_VH
`define DCL_CONSTS_VH

// ----------------------------------------
// transfer size codes
// ----------------------------------------
`define DCL_SIZE_LONG      2'h0
`define DCL_SIZE_BYTE      2'h1
`define DCL_SIZE_WORD      2'h2
`define DCL_SIZE_LINE      2'h3

// ----------------------------------------
// dram port width codes
// ----------------------------------------
`define DCL_PORT_8         2'h0
`define DCL_PORT_16        2'h1
`define DCL_PORT_32        2'h2

// ----------------------------------------
// timing register fields and reset values
// ----------------------------------------
`define DCL_TIM_W          8
`define DCL_TIM_RCD_LSB    0
`define DCL_TIM_CAS_LSB    4
`define DCL_TIM_FLD_W      4
`define DCL_TIM_RESET      8'h11
`define DCL_STROBE_OFF     4'hF

`endif

// file: rtl/dcl_lane_decode.v
/*
  combinational byte lane decoder: maps transfer size, port width and
  the two low address bits to four active-low column strobe levels.
  assumes inputs are stable and from the same clock domain.
*/
`timescale 1ns/1ns
`include "dcl_consts.vh"

module dcl_lane_decode (
  input  wire [1:0] transfer_size,
  input  wire [1:0] port_width,
  input  wire [1:0] addr_lo,
  output reg  [3:0] lane_n
);

  // ----------------------------------------
  // lane decode
  // ----------------------------------------
  // size code decode
  always @* begin
    lane_n = `DCL_STROBE_OFF;
    case (port_width)
      `DCL_PORT_8: lane_n = 4'hE;
      `DCL_PORT_16: begin
        if (transfer_size == `DCL_SIZE_BYTE) begin
          lane_n = addr_lo[0] ? 4'hD : 4'hE;
        end else begin
          lane_n = 4'hC;
        end
      end
      `DCL_PORT_32: begin
        case (transfer_size)
          `DCL_SIZE_BYTE: lane_n = ~(4'h1 << addr_lo);
          `DCL_SIZE_WORD: lane_n = addr_lo[1] ? 4'h3 : 4'hC;
          default:        lane_n = 4'h0;
        endcase
      end
      // unused width code keeps lanes off
      default: lane_n = `DCL_STROBE_OFF;
    endcase
  end

endmodule

// file: rtl/dcl_cas_lane.v
/*
  column strobe and dram write strobe sequencer for two dram banks.
  bit i of cas_n drives lane i: 0 = D[31:24] ... 3 = D[7:0].
  assumes request inputs come from logic on clk; timing value is
  held static by software while accesses run.
*/
// Functional notes
// - four active-low strobes, lane 0 msb
// - 8-bit port uses strobe 0 only
// - 16-bit byte by a0, else pair
// - 32-bit byte picks strobe at a[1:0]
// - 32-bit word halves, long all four
// - size 01 byte 10 word 00 long 11 line
// - timing register shapes strobe delay, width
// - write strobe low on dram writes only
// - write strobe high during refresh cycles
// - write strobe valid only in dram cycles
// - one row strobe per bank
`timescale 1ns/1ns
`include "dcl_consts.vh"

module dcl_cas_lane (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  access_start,
  input  wire                  access_bank,
  input  wire                  access_write,
  input  wire [1:0]            transfer_size,
  input  wire [1:0]            port_width,
  input  wire [1:0]            addr_lo,
  input  wire                  refresh_start,
  input  wire [`DCL_TIM_W-1:0] dram_timing_register,
  output wire [3:0]            cas_n,
  output wire [1:0]            ras_n,
  output wire                  dram_write_strobe_n,
  output wire                  busy
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ROW  = 4'h2;
  localparam [3:0] ST_COL  = 4'h4;
  localparam [3:0] ST_REF  = 4'h8;

  reg  [3:0] state_q;
  reg  [3:0] state_d;
  reg  [3:0] cnt_q;
  reg  [3:0] cnt_d;
  reg  [3:0] lanes_q;
  reg        bank_q;
  reg        write_q;
  reg  [3:0] cas_q;
  reg  [3:0] cas_d;
  reg  [1:0] ras_q;
  reg  [1:0] ras_d;
  reg        wr_n_q;
  reg        wr_n_d;
  wire [3:0] lanes_dec;
  // an access is taken only from idle, and refresh outranks it
  wire       acc_take = state_q[0] & access_start & ~refresh_start;

  // field extraction used for both timing phases
  function [3:0] tim_field;
    input [`DCL_TIM_W-1:0] t;
    input                  sel;
    begin
      tim_field = sel ? t[`DCL_TIM_CAS_LSB +: `DCL_TIM_FLD_W] : t[`DCL_TIM_RCD_LSB +: `DCL_TIM_FLD_W];
    end
  endfunction

  // idle takes the request pin, a running access its held copy
  function pick_src;
    input [3:0] st;
    input       now_v;
    input       held_v;
    begin
      pick_src = st[0] ? now_v : held_v;
    end
  endfunction

  dcl_lane_decode dcl_lane_decode_inst (
    .transfer_size (transfer_size),
    .port_width    (port_width),
    .addr_lo       (addr_lo),
    .lane_n        (lanes_dec)
  );

  // ----------------------------------------
  // status
  // ----------------------------------------
  // one-hot: bit 0 alone marks idle
  assign busy = ~state_q[0];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        // refresh first: it must not starve behind accesses
        if (refresh_start) begin
          state_d = ST_REF;
          cnt_d   = tim_field(dram_timing_register, 1'h1);
        end else if (access_start) begin
          state_d = ST_ROW;
          cnt_d   = tim_field(dram_timing_register, 1'h0);
        end
      end
      ST_ROW: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_COL;
          cnt_d   = tim_field(dram_timing_register, 1'h1);
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_COL, ST_REF: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      // stray code after an upset: back to idle
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 4'h0;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------
  // access capture
  // ----------------------------------------
  // request pins may move after the take edge, so hold what they said
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lanes_q <= `DCL_STROBE_OFF;
      bank_q  <= 1'h0;
      write_q <= 1'h0;
    end else if (acc_take) begin
      lanes_q <= lanes_dec;
      bank_q  <= access_bank;
      write_q <= access_write;
    end
  end

  // ----------------------------------------
  // strobe next values
  // ----------------------------------------
  // decoded from the next state so pins move on the edge the state does
  always @* begin
    cas_d  = `DCL_STROBE_OFF;
    ras_d  = 2'h3;
    wr_n_d = 1'h1;
    case (state_d)
      ST_ROW: begin
        ras_d[pick_src(state_q, access_bank, bank_q)] = 1'h0;
        wr_n_d = ~pick_src(state_q, access_write, write_q);
      end
      ST_COL: begin
        ras_d[bank_q] = 1'h0;
        cas_d  = lanes_q;
        wr_n_d = ~write_q;
      end
      ST_REF: begin
        cas_d = 4'h0;
        ras_d = 2'h0;
      end
      default: begin
        cas_d = `DCL_STROBE_OFF;
      end
    endcase
  end

  // ----------------------------------------
  // registered pin drive
  // ----------------------------------------
  // pins come straight from flops: no decode glitch reaches the dram
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cas_q  <= `DCL_STROBE_OFF;
      ras_q  <= 2'h3;
      wr_n_q <= 1'h1;
    end else begin
      cas_q  <= cas_d;
      ras_q  <= ras_d;
      wr_n_q <= wr_n_d;
    end
  end

  assign cas_n               = cas_q;
  assign ras_n               = ras_q;
  assign dram_write_strobe_n = wr_n_q;

endmodule

// file: testbench/dcl_cas_lane_chk.sv
/* assertions on the ports of dcl_cas_lane.
   assumes the timing value stays static while accesses run. */
`timescale 1ns/1ns
module dcl_cas_lane_chk (
  input wire       clk,
  input wire       rst,
  input wire       access_start,
  input wire       access_bank,
  input wire       access_write,
  input wire [1:0] transfer_size,
  input wire [1:0] port_width,
  input wire [1:0] addr_lo,
  input wire       refresh_start,
  input wire [7:0] dram_timing_register,
  input wire [3:0] cas_n,
  input wire [1:0] ras_n,
  input wire       dram_write_strobe_n,
  input wire       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       take = !busy && (access_start || refresh_start);
  wire       acc  = take && !refresh_start;
  wire       on   = cas_n != 4'hF && ras_n != 2'h0;
  reg  [7:0] tm_q;
  wire [5:0] r    = {2'h0, tm_q[3:0]};
  wire [5:0] c    = {2'h0, tm_q[7:4]};
  reg  [1:0] sz_q, pw_q, a_q;
  reg  [5:0] n_q;
  reg        rf_q;
  // edge count since take; timing is held from the take edge, as the
  // bench may reprogram it in the cycle that busy falls
  always @(posedge clk) begin
    if (take) begin
      {sz_q, pw_q, a_q, rf_q, tm_q} <= {transfer_size, port_width, addr_lo, refresh_start, dram_timing_register};
      n_q <= 6'h00;
    end else begin
      n_q <= n_q + 6'h01;
    end
  end
  // ----
  // assertions
  // ----
  a_idle_negated: assert property (!busy |-> cas_n == 4'hF && ras_n == 2'h3 && dram_write_strobe_n)
    else $error("strobe active while idle");
  a_row_bank: assert property (acc |=> ras_n == ($past(access_bank) ? 2'h1 : 2'h2))
    else $error("wrong row strobe");
  a_write_dir: assert property (acc |=> busy && dram_write_strobe_n == !$past(access_write))
    else $error("write strobe level");
  a_refresh_write: assert property (take && refresh_start |=> dram_write_strobe_n && cas_n == 4'h0 && ras_n == 2'h0)
    else $error("refresh strobes");
  a_lane_narrow: assert property (on && pw_q == 2'h0 |-> cas_n == 4'hE)
    else $error("8-bit lane");
  a_lane_half: assert property (on && pw_q == 2'h1 |->
    cas_n == (sz_q != 2'h1 ? 4'hC : a_q[0] ? 4'hD : 4'hE))
    else $error("16-bit lanes");
  a_lane_byte: assert property (on && pw_q == 2'h2 && sz_q == 2'h1 |-> cas_n == ~(4'h1 << a_q))
    else $error("32-bit byte lane");
  a_lane_wide: assert property (on && pw_q == 2'h2 && sz_q != 2'h1 |->
    cas_n == (sz_q != 2'h2 ? 4'h0 : a_q[1] ? 4'h3 : 4'hC))
    else $error("32-bit wide lanes");
  a_cas_delay: assert property (on && $past(cas_n) == 4'hF |-> n_q == r + 6'h01)
    else $error("column strobe delay");
  a_cas_width: assert property ($fell(busy) && !rf_q |-> $past(n_q) == r + c + 6'h01)
    else $error("column strobe width");
endmodule
bind dcl_cas_lane dcl_cas_lane_chk dcl_cas_lane_chk_inst (
  .clk                  (clk),
  .rst                  (rst),
  .access_start         (access_start),
  .access_bank          (access_bank),
  .access_write         (access_write),
  .transfer_size        (transfer_size),
  .port_width           (port_width),
  .addr_lo              (addr_lo),
  .refresh_start        (refresh_start),
  .dram_timing_register (dram_timing_register),
  .cas_n                (cas_n),
  .ras_n                (ras_n),
  .dram_write_strobe_n  (dram_write_strobe_n),
  .busy                 (busy)
);

// file: testbench/dcl_dram_bank.sv
/* dram bank stand-in: records lanes, write level and strobe timing.
   assumes one access or refresh at a time. */
`timescale 1ns/1ns
module dcl_dram_bank (
  input  wire       clk,
  input  wire [3:0] cas_n,
  input  wire [1:0] ras_n,
  input  wire       dram_write_strobe_n,
  output reg  [3:0] lanes,
  output reg  [3:0] npre,
  output reg  [3:0] ncas,
  output reg        wr_seen
);
  reg act_q = 1'h0;
  always @(posedge clk) begin
    act_q <= ras_n != 2'h3;
    if (ras_n != 2'h3) begin
      lanes   <= (act_q ? lanes : 4'h0) | ~cas_n;
      npre    <= (act_q ? npre : 4'h0) + (cas_n == 4'hF);
      ncas    <= (act_q ? ncas : 4'h0) + (cas_n != 4'hF);
      wr_seen <= !dram_write_strobe_n;
    end
  end
endmodule

// file: testbench/dcl_cas_lane_bench.sv
/* testbench for dcl_cas_lane with a dram bank model.
   assumes the checker is bound to the design. */
`timescale 1ns/1ns
module dcl_cas_lane_bench;
  logic       clk = 1'h0, rst = 1'h1, access_start = 1'h0, access_bank = 1'h0;
  logic       access_write = 1'h0, refresh_start = 1'h0;
  logic [1:0] transfer_size = 2'h0, port_width = 2'h0, addr_lo = 2'h0;
  logic [7:0] dram_timing_register = 8'h00;
  wire  [3:0] cas_n, lanes, npre, ncas;
  wire  [1:0] ras_n;
  wire        dram_write_strobe_n, busy, wr_seen;
  int         err_total = 0, n_tests = 0, cyc = 0;
  always #25 clk = ~clk;
  dcl_cas_lane dcl_cas_lane_inst (
    .clk                  (clk),
    .rst                  (rst),
    .access_start         (access_start),
    .access_bank          (access_bank),
    .access_write         (access_write),
    .transfer_size        (transfer_size),
    .port_width           (port_width),
    .addr_lo              (addr_lo),
    .refresh_start        (refresh_start),
    .dram_timing_register (dram_timing_register),
    .cas_n                (cas_n),
    .ras_n                (ras_n),
    .dram_write_strobe_n  (dram_write_strobe_n),
    .busy                 (busy)
  );
  dcl_dram_bank dcl_dram_bank_inst (
    .clk                 (clk),
    .cas_n               (cas_n),
    .ras_n               (ras_n),
    .dram_write_strobe_n (dram_write_strobe_n),
    .lanes               (lanes),
    .npre                (npre),
    .ncas                (ncas),
    .wr_seen             (wr_seen)
  );
  // ----
  // tasks
  // ----
  task results;
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(string s, logic [3:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  function logic [3:0] lane(logic [1:0] s, p, x);
    if (p == 2'h0) return 4'h1;
    if (p == 2'h1) return s != 2'h1 ? 4'h3 : x[0] ? 4'h2 : 4'h1;
    // unused width code: no lane may open
    if (p == 2'h3) return 4'h0;
    return s == 2'h1 ? 4'h1 << x : s == 2'h2 ? (x[1] ? 4'hC : 4'h3) : 4'hF;
  endfunction
  // one-cycle request, then wait for idle
  task run(logic [1:0] s, p, x, logic w, r);
    @(posedge clk) #5;
    {transfer_size, port_width, addr_lo, access_write, access_bank} = {s, p, x, w, x[0]};
    {access_start, refresh_start} = {1'h1, r};
    @(posedge clk) #5;
    {access_start, refresh_start} = 2'h0;
    for (int i = 0; i < 40 && busy !== 1'h0; i++) @(posedge clk) #5;
    chk("busy", 4'h0, {3'h0, busy});
  endtask
  // odd-address accesses wider than a byte on non-8-bit ports are left out: lanes undefined there
  task t_lanes;
    for (int p = 0; p < 4; p++)
      for (int s = 0; s < 4; s++)
        for (int x = 0; x < 4; x++)
          if (s == 1 || p == 0 || !x[0]) begin
            run(s[1:0], p[1:0], x[1:0], x[1], 1'h0);
            chk("lanes", lane(s[1:0], p[1:0], x[1:0]), lanes);
            chk("write", {3'h0, x[1]}, {3'h0, wr_seen});
          end
  endtask
  task t_timing;
    dram_timing_register = 8'h23;
    run(2'h1, 2'h2, 2'h3, 1'h1, 1'h0);
    chk("delay", 4'h4, npre);
    chk("width", 4'h3, ncas);
    dram_timing_register = 8'h00;
  endtask
  task t_refresh;
    run(2'h1, 2'h2, 2'h0, 1'h1, 1'h1);
    chk("refresh lanes", 4'hF, lanes);
    chk("refresh write", 4'h0, {3'h0, wr_seen});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #5 rst = 1'h0;
    t_lanes;
    t_timing;
    t_refresh;
    results;
  end
endmodule
